// [src/bii_map.vh]
/*
 Constants for the burner input interlock: register offsets, field
 positions, controller state codes, action codes and alert bit numbers.
 Assumes inclusion by bare name from the design file.
*/
`ifndef BII_MAP_VH
`define BII_MAP_VH

// Register byte offsets
`define BII_CFG_OFS        12'h000
`define BII_LIVE_OFS       12'h004
`define BII_STATUS_OFS     12'h008
`define BII_IRQ_EN_OFS     12'h00C
`define BII_IRQ_CLR_OFS    12'h010

// Configuration register fields
`define BII_CFG_AUX_LSB    0
`define BII_CFG_AUX_MSB    1
`define BII_CFG_RESTART    4
`define BII_CFG_RMODE_MP   5
`define BII_CFG_MP_MASK    6
`define BII_CFG_FVO_PURGE  7
`define BII_CFG_PILOT_AMO  8
`define BII_CFG_FP_LSB     9
`define BII_CFG_FP_MSB     10
`define BII_CFG_WIDTH      11
`define BII_CFG_RESET      11'h000

// Auxiliary contact modes
`define BII_AUX_NONE       2'h0
`define BII_AUX_LOW_FUEL   2'h1
`define BII_AUX_AIRFLOW    2'h2
`define BII_AUX_MAIN_PERM  2'h3

// Fuel pressure input modes
`define BII_FP_DISABLED    2'h0
`define BII_FP_DRY         2'h1
`define BII_FP_DRY_HIGH    2'h2
`define BII_FP_ANALOG      2'h3

// Controller state codes
`define BII_ST_IDLE        3'h0
`define BII_ST_CHECKS      3'h1
`define BII_ST_PREPURGE    3'h2
`define BII_ST_PILOT       3'h3
`define BII_ST_MAIN        3'h4
`define BII_ST_WAITING     3'h5
`define BII_ST_LOCKOUT     3'h6
`define BII_ST_ALARM       3'h7

// Requested transition
`define BII_ACT_NONE       3'h0
`define BII_ACT_ADVANCE    3'h1
`define BII_ACT_PILOT      3'h2
`define BII_ACT_PURGE_PIL  3'h3
`define BII_ACT_WAIT       3'h4
`define BII_ACT_ALARM      3'h5
`define BII_ACT_LOCKOUT    3'h6

// Alert bit numbers
`define BII_AL_LP_ALARM    0
`define BII_AL_LP_WAIT     1
`define BII_AL_LP_MP       2
`define BII_AL_AIR_STUCK   3
`define BII_AL_AIR_PURGE   4
`define BII_AL_AIR_RUN     5
`define BII_AL_CONTACT_MP  6
`define BII_AL_ESTOP       7
`define BII_AL_FP_OPEN     8
`define BII_AL_HP_WARN     9
`define BII_AL_HP_MAIN     10
`define BII_AL_WIDTH       11
`define BII_AL_RESET       11'h000

`endif

// [src/bii_interlock.v]
/*
 Burner input interlock: evaluates auxiliary, emergency stop and fuel
 pressure contacts against the controller state and configuration, and
 requests a transition plus alerts. APB slave for configuration, status
 and interrupts. Also holds the two flip-flop synchroniser used for each
 field contact.
 Assumes field contacts are asynchronous (high means energized) and
 ctrl_state_i comes from logic on mclk_i.
*/
`timescale 1ns/1ps
`include "bii_map.vh"

// Two flip-flop synchroniser for one asynchronous field contact
module bii_sync (
   input  wire mclk_i,
   input  wire reset_i,
   input  wire async_i,
   output wire sync_o
);

   reg meta_r;
   reg hold_r;

   // Reset reads the contact as de-energized
   always @(posedge mclk_i) begin
      if (reset_i) begin
         meta_r <= 1'b0;
         hold_r <= 1'b0;
      end else begin
         meta_r <= async_i;
         hold_r <= meta_r;
      end
   end

   assign sync_o = hold_r;

endmodule // bii_sync

module bii_interlock (
   input  wire        mclk_i,
   input  wire        reset_i,
   input  wire        psel_i,
   input  wire        penable_i,
   input  wire        pwrite_i,
   input  wire [11:0] paddr_i,
   input  wire [31:0] pwdata_i,
   output reg  [31:0] prdata_o,
   output wire        pready_o,
   output wire        pslverr_o,
   input  wire [2:0]  ctrl_state_i,
   input  wire        aux_contact_i,
   input  wire        emergency_stop_input_i,
   input  wire        fuel_pressure_contact_i,
   output reg  [2:0]  action_o,
   output reg  [10:0] alert_o,
   output wire        irq_o
);

   reg  [`BII_CFG_WIDTH-1:0] cfg_r;
   reg  [`BII_AL_WIDTH-1:0]  status_r;
   reg  [`BII_AL_WIDTH-1:0]  irq_en_r;
   reg  [`BII_AL_WIDTH-1:0]  status_nxt;
   reg  [31:0]               rdata_nxt;
   reg  [`BII_AL_WIDTH-1:0]  al_nxt;
   reg  [2:0]                act_nxt;
   reg                       lock_c;
   reg                       alarm_c;
   reg                       wait_c;
   reg                       pilot_c;
   reg                       adv_c;
   reg                       mp_c;

   wire aux_on;
   wire estop_on;
   wire fp_on;
   wire mp_live  = alert_o[`BII_AL_LP_MP] || alert_o[`BII_AL_CONTACT_MP];
   wire [1:0] aux_mode = cfg_r[`BII_CFG_AUX_MSB:`BII_CFG_AUX_LSB];
   wire [1:0] fp_mode  = cfg_r[`BII_CFG_FP_MSB:`BII_CFG_FP_LSB];
   wire st_main  = (ctrl_state_i == `BII_ST_MAIN);
   wire st_fuel  = st_main || (ctrl_state_i == `BII_ST_PILOT);
   wire st_stop  = (ctrl_state_i == `BII_ST_IDLE) ||
                   (ctrl_state_i == `BII_ST_LOCKOUT) ||
                   (ctrl_state_i == `BII_ST_ALARM);

   wire setup    = psel_i && !penable_i;
   wire wr_take  = psel_i && penable_i && pwrite_i;
   wire wr_cfg   = wr_take && (paddr_i == `BII_CFG_OFS);
   wire wr_en    = wr_take && (paddr_i == `BII_IRQ_EN_OFS);
   wire wr_clr   = wr_take && (paddr_i == `BII_IRQ_CLR_OFS);
   wire mapped   = (paddr_i == `BII_CFG_OFS) ||
                   (paddr_i == `BII_LIVE_OFS) ||
                   (paddr_i == `BII_STATUS_OFS) ||
                   (paddr_i == `BII_IRQ_EN_OFS) ||
                   (paddr_i == `BII_IRQ_CLR_OFS);

   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i && penable_i && !mapped;
   assign irq_o     = |(status_r & irq_en_r);

   // Field contacts pass two flip-flops before any logic reads them
   bii_sync u_sync_aux (
      .mclk_i  (mclk_i),
      .reset_i (reset_i),
      .async_i (aux_contact_i),
      .sync_o  (aux_on)
   );

   bii_sync u_sync_estop (
      .mclk_i  (mclk_i),
      .reset_i (reset_i),
      .async_i (emergency_stop_input_i),
      .sync_o  (estop_on)
   );

   bii_sync u_sync_fp (
      .mclk_i  (mclk_i),
      .reset_i (reset_i),
      .async_i (fuel_pressure_contact_i),
      .sync_o  (fp_on)
   );

   always @* begin
      al_nxt  = `BII_AL_RESET;
      lock_c  = 1'b0;
      alarm_c = 1'b0;
      wait_c  = 1'b0;
      pilot_c = 1'b0;
      adv_c   = 1'b0;
      mp_c    = 1'b0;
      case (aux_mode)
         `BII_AUX_LOW_FUEL: begin
            if (!aux_on) begin
               if (!cfg_r[`BII_CFG_RESTART]) begin
                  al_nxt[`BII_AL_LP_ALARM] = 1'b1;
                  lock_c = 1'b1;
               end else if (cfg_r[`BII_CFG_RMODE_MP]) begin
                  al_nxt[`BII_AL_LP_MP] = 1'b1;
                  mp_c    = 1'b1;
                  pilot_c = st_main;
               end else begin
                  al_nxt[`BII_AL_LP_WAIT] = 1'b1;
                  wait_c = !st_stop;
               end
            end
         end
         `BII_AUX_AIRFLOW: begin
            if (ctrl_state_i == `BII_ST_CHECKS) begin
               if (aux_on) begin
                  al_nxt[`BII_AL_AIR_STUCK] = 1'b1;
                  lock_c = 1'b1;
               end else begin
                  adv_c = 1'b1;
               end
            end else if (ctrl_state_i == `BII_ST_PREPURGE && !aux_on) begin
               al_nxt[`BII_AL_AIR_PURGE] = 1'b1;
               lock_c = 1'b1;
            end
            if (st_fuel && !aux_on && !cfg_r[`BII_CFG_FVO_PURGE]) begin
               al_nxt[`BII_AL_AIR_RUN] = 1'b1;
               lock_c = 1'b1;
            end
         end
         `BII_AUX_MAIN_PERM: begin
            if (!aux_on) begin
               al_nxt[`BII_AL_CONTACT_MP] = 1'b1;
               mp_c    = 1'b1;
               pilot_c = st_main;
            end
         end
         default: begin
         end
      endcase
      // masking hides wait
      // A main permissive alert raised now or already live counts
      if (cfg_r[`BII_CFG_MP_MASK] && (mp_c || mp_live)) begin
         al_nxt[`BII_AL_LP_WAIT] = 1'b0;
         wait_c = 1'b0;
      end
      if (!estop_on) begin
         al_nxt[`BII_AL_ESTOP] = 1'b1;
         if (st_stop)
            alarm_c = 1'b1;
         else
            lock_c = 1'b1;
      end
      case (fp_mode)
         `BII_FP_DRY: begin
            if (!fp_on) begin
               al_nxt[`BII_AL_FP_OPEN] = 1'b1;
               if (st_stop)
                  alarm_c = 1'b1;
               else
                  lock_c = 1'b1;
            end
         end
         `BII_FP_DRY_HIGH: begin
            if (!fp_on) begin
               if (st_main) begin
                  al_nxt[`BII_AL_HP_MAIN] = 1'b1;
                  lock_c = 1'b1;
               end else begin
                  al_nxt[`BII_AL_HP_WARN] = 1'b1;
               end
            end
         end
         default: begin
         end
      endcase
      if (lock_c)
         act_nxt = `BII_ACT_LOCKOUT;
      else if (alarm_c)
         act_nxt = `BII_ACT_ALARM;
      else if (wait_c)
         act_nxt = `BII_ACT_WAIT;
      else if (pilot_c)
         act_nxt = cfg_r[`BII_CFG_PILOT_AMO] ? `BII_ACT_PURGE_PIL
                                             : `BII_ACT_PILOT;
      else if (adv_c)
         act_nxt = `BII_ACT_ADVANCE;
      else
         act_nxt = `BII_ACT_NONE;
   end

   always @(posedge mclk_i) begin
      if (reset_i) begin
         action_o <= `BII_ACT_NONE;
         alert_o  <= `BII_AL_RESET;
      end else begin
         action_o <= act_nxt;
         alert_o  <= al_nxt;
      end
   end

   // Configuration and interrupt enable registers
   always @(posedge mclk_i) begin
      if (reset_i) begin
         cfg_r    <= `BII_CFG_RESET;
         irq_en_r <= `BII_AL_RESET;
      end else begin
         if (wr_cfg)
            cfg_r <= pwdata_i[`BII_CFG_WIDTH-1:0];
         if (wr_en)
            irq_en_r <= pwdata_i[`BII_AL_WIDTH-1:0];
      end
   end

   // Sticky status; a new alert wins over a clear in the same cycle
   always @* begin
      status_nxt = status_r | alert_o;
      if (wr_clr)
         status_nxt = (status_r & ~pwdata_i[`BII_AL_WIDTH-1:0]) | alert_o;
   end

   always @(posedge mclk_i) begin
      if (reset_i)
         status_r <= `BII_AL_RESET;
      else
         status_r <= status_nxt;
   end

   // Read mux; write-only and unmapped offsets read as zero
   always @* begin
      case (paddr_i)
         `BII_CFG_OFS:    rdata_nxt = {21'h000000, cfg_r};
         `BII_LIVE_OFS:   rdata_nxt = {13'h0000, action_o, 5'h00,
                                       alert_o};
         `BII_STATUS_OFS: rdata_nxt = {21'h000000, status_r};
         `BII_IRQ_EN_OFS: rdata_nxt = {21'h000000, irq_en_r};
         default:         rdata_nxt = 32'h00000000;
      endcase
   end

   // Read data is captured in the setup cycle
   always @(posedge mclk_i) begin
      if (reset_i)
         prdata_o <= 32'h00000000;
      else if (setup && !pwrite_i)
         prdata_o <= rdata_nxt;
   end

endmodule // bii_interlock

// [testbench/bii_checker.sv]
/* Port assertions for the burner input interlock.
   Bound to bii_interlock from the bench top file. */
`timescale 1ns/1ps
module bii_checker (
   input wire logic        mclk_i,
   input wire logic        reset_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   input wire logic [2:0]  ctrl_state_i,
   input wire logic        emergency_stop_input_i,
   input wire logic [2:0]  action_o,
   input wire logic [10:0] alert_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   // Stop contact held open or closed long enough to pass the syncs
   sequence es_open; (!emergency_stop_input_i) [*4]; endsequence
   sequence es_shut; emergency_stop_input_i [*4]; endsequence
   sequence es_run; es_open ##0 ctrl_state_i inside {[1:5]}; endsequence
   sequence es_idle;
      es_open ##0 !(ctrl_state_i inside {[1:5]});
   endsequence
   // Main permissive alert raised while the controller was in main
   sequence mp_main;
      (alert_o[2] || alert_o[6]) && $past(ctrl_state_i) == 3'h4;
   endsequence
   a_ready_high: assert property (pready_o) else $error("pready low");
   a_err_access: assert property (pslverr_o |-> psel_i && penable_i)
      else $error("pslverr outside access");
   a_rdata_hold: assert property (!(psel_i && !penable_i && !pwrite_i)
      |=> $stable(prdata_o)) else $error("prdata moved");
   a_estop_alert: assert property (es_open |=> alert_o[7])
      else $error("stop alert missing");
   a_estop_clear: assert property (es_shut |=> !alert_o[7])
      else $error("stop alert stuck");
   a_estop_run: assert property (es_run |=> action_o == 3'h6)
      else $error("no lockout");
   a_estop_stop: assert property (es_idle |=> action_o >= 3'h5)
      else $error("no alarm");
   a_lp_lock: assert property (alert_o[0] |-> action_o == 3'h6)
      else $error("low press no lockout");
   a_air_lock: assert property (|alert_o[5:3] |-> action_o == 3'h6)
      else $error("airflow no lockout");
   a_mp_pilot: assert property (mp_main |-> action_o >= 3'h2)
      else $error("main not dropped");
endmodule // bii_checker

// [testbench/bii_field.sv]
/* Field contact model: switches, safety contacts, shutdown loop.
   Contacts follow the bench's demand just after each clock edge. */
`timescale 1ns/1ps
module bii_field (
   input  wire logic       mclk_i,
   input  wire logic [2:0] want_i,
   output logic            aux_o,
   output logic            estop_o,
   output logic            fp_o
);
   // aux, stop and fuel pressure contacts each copy one bit of want_i on every edge
   always @(posedge mclk_i) {aux_o, estop_o, fp_o} <= want_i;
endmodule // bii_field

// [testbench/bii_interlock_tb.sv]
/* Self-checking bench for the burner input interlock.
   Drives APB and the field model; expectations come from expv. */
`timescale 1ns/1ps
module bii_interlock_tb;
   logic        mclk_i = 0, reset_i = 1, psel = 0, pen = 0, pwr = 0, se;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwd = 32'h0, q, r, seed = 32'hFBA9;
   logic [2:0]  st = 3'h0, want = 3'h7, act;
   logic [10:0] c, en, alert;
   logic [13:0] e;
   wire         prdy, perr, irq, aux, es, fp;
   wire  [31:0] prdata;
   int          err_total = 0, n_checks = 0, i;
   always #25 mclk_i = ~mclk_i;
   bii_interlock u_dut (.mclk_i(mclk_i), .reset_i(reset_i), .psel_i(psel),
      .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwd),
      .prdata_o(prdata), .pready_o(prdy), .pslverr_o(perr), .irq_o(irq),
      .ctrl_state_i(st), .aux_contact_i(aux), .emergency_stop_input_i(es),
      .fuel_pressure_contact_i(fp), .action_o(act), .alert_o(alert));
   bii_field u_fld (.mclk_i(mclk_i), .want_i(want), .aux_o(aux),
      .estop_o(es), .fp_o(fp));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [13:0] expv(input logic [10:0] c,
      input logic [2:0] s, input logic a, e, f);
      logic [10:0] al;
      logic [2:0]  ac;
      logic        run, mn, lk, am, wt, pl, adv;
      al = 11'h000;
      {lk, am, wt, pl, adv} = 5'h00;
      run = s >= 3'h1 && s <= 3'h5;
      mn = s == 3'h4;
      case (c[1:0])
         2'h1: if (!a) begin
            if (!c[4]) {al[0], lk} = 2'h3;
            else if (!c[5]) {al[1], wt} = {1'b1, run};
            else {al[2], pl} = {1'b1, mn};
         end
         2'h2: if (s == 3'h1) {al[3], lk, adv} = {a, a, !a};
            else if (!a && s == 3'h2) {al[4], lk} = 2'h3;
            else if (!a && !c[7] && (mn || s == 3'h3)) {al[5], lk} = 2'h3;
         2'h3: if (!a) {al[6], pl} = {1'b1, mn};
         default: ;
      endcase
      if (!e) {al[7], lk, am} = {1'b1, run | lk, !run | am};
      if (c[10:9] == 2'h1 && !f) {al[8], lk, am} = {1'b1, run | lk, !run | am};
      if (c[10:9] == 2'h2 && !f) {al[10], al[9], lk} = {mn, !mn, mn | lk};
      ac = lk ? 3'h6 : am ? 3'h5 : wt ? 3'h4 : {2'h0, adv};
      if (ac < 3'h4 && pl) ac = c[8] ? 3'h3 : 3'h2;
      return {ac, al};
   endfunction
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge mclk_i);
      {psel, pen, pwr, paddr, pwd} <= {2'h2, w, a, d};
      @(posedge mclk_i);
      pen <= 1'b1;
      do begin
         @(posedge mclk_i);
      end while (prdy !== 1'b1);
      q = prdata;
      se = perr;
      {psel, pen} <= 2'h0;
   endtask
   task end_sim();
      if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #1000000;
      err_total++;
      end_sim();
   end
   initial begin
      repeat (6) @(posedge mclk_i);
      reset_i <= 1'b0;
      apb(0, 12'h000, 0);
      chk("cfg reset", q, 0);
      apb(0, 12'h014, 0);
      chk("unmapped", {q[30:0], se}, 1);
      for (i = 0; i < 128; i++) begin
         r = rnd();
         c = r[10:0];
         if (i < 64) c[1:0] = i[4:3];
         st <= (i < 64) ? i[2:0] : r[13:11];
         want <= r[16:14];
         en = r[27:17];
         apb(1, 12'h000, {21'h0, c});
         apb(1, 12'h00C, {21'h0, en});
         apb(1, 12'h010, 32'h7FF);
         repeat (5) @(posedge mclk_i);
         e = expv(c, st, want[2], want[1], want[0]);
         chk("action", act, e[13:11]);
         chk("alert", alert, e[10:0]);
         apb(0, 12'h004, 0);
         chk("live", q, {13'h0, e[13:11], 5'h0, e[10:0]});
         apb(0, 12'h008, 0);
         chk("status", q, e[10:0]);
         chk("irq", irq, |(e[10:0] & en));
         {st, want} <= 6'h07;
         repeat (5) @(posedge mclk_i);
      end
      apb(1, 12'h010, 32'h7FF);
      apb(0, 12'h008, 0);
      chk("cleared", {q[30:0], irq}, 0);
      end_sim();
   end
endmodule // bii_interlock_tb
bind bii_interlock bii_checker u_chk (.mclk_i(mclk_i), .reset_i(reset_i),
   .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
   .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .ctrl_state_i(ctrl_state_i), .action_o(action_o), .alert_o(alert_o),
   .emergency_stop_input_i(emergency_stop_input_i));
